// file: rtl/fct_tx_req.sv
// transmit clock indication, boundary flag and data request encoder front end
//
// What this block does
// - clock indications only in working, open, not-enabled
// - indication rate: char/1, char/2, char/4 per width
// - every indication carries word or null boundary
// - working entry aligns words, sends idle words
// - boundary every fourth, second, every indication
// - lane types: data, non-repeating, repeating set
// - sets use lane one; data uses one, two or four lanes by width
// - characters leave in lane order, lane one first
// - any ordered set code accepted, both set types
// - word path: four bytes or one set
// - set on null boundary in working enters failure
// - failure: no indications, requests refused
// - half is two lanes, word four lanes
// - repeating set resent until next request
`timescale 1ns/100ps
module fct_tx_req #(
   parameter int unsigned CHAR_CYC = fct_pkg::CHAR_CYC_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [fct_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [fct_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // laser safety trip, asynchronous pin
   input wire logic laser_trip,
   // framing level side
   output logic tx_clk_ind,
   output logic tx_boundary_word,
   input wire logic req_valid,
   input wire fct_pkg::fct_req_t req,
   output logic req_ready,
   // line side
   output fct_pkg::fct_char_t line_char,
   output logic line_char_valid,
   output logic line_en,
   output fct_pkg::fct_state_t tx_state
);

   localparam int CDW = (CHAR_CYC > 1) ? $clog2(CHAR_CYC) : 1;
   localparam logic [CDW-1:0] DIV_LAST = CDW'(CHAR_CYC - 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sync;
      logic trip;
      logic [CDW-1:0] div;
      logic [1:0] lph;
      fct_pkg::fct_state_t st;
      logic en;
      fct_pkg::fct_width_t wid;
      fct_pkg::fct_word_t stg;
      logic rep_on;
      logic [7:0] rep_code;
      logic [15:0] viol;
   } fct_tx_s_t;

   localparam fct_tx_s_t S_RST = '{
      sync: 3'h0,
      trip: 1'b0,
      div: '0,
      lph: 2'h0,
      st: fct_pkg::FCT_ST_NOT_EN,
      en: fct_pkg::CTRL_EN_RST,
      wid: fct_pkg::FCT_W_BYTE,
      stg: '{os: 1'b1, code: {24'h000000, fct_pkg::IDLE_OS_CODE}},
      rep_on: 1'b0,
      rep_code: 8'h00,
      viol: 16'h0000
   };

   fct_tx_s_t s_r;
   fct_tx_s_t s_nxt;

   logic reg_wr;
   logic [fct_pkg::ADDR_W-1:0] reg_waddr;
   logic [31:0] reg_wdata;
   logic [3:0] reg_wstrb;
   logic reg_wr_ok;
   logic [fct_pkg::ADDR_W-1:0] reg_raddr;
   logic [31:0] reg_rdata;
   logic reg_rd_ok;

   logic tick;
   logic ind;
   logic bnd;
   logic take;
   logic enter_work;
   logic ser_stb;
   logic [2:0] nlanes;
   fct_pkg::fct_word_t dflt;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   fct_axil_slv u_slv (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .reg_wr(reg_wr),
      .reg_waddr(reg_waddr),
      .reg_wdata(reg_wdata),
      .reg_wstrb(reg_wstrb),
      .reg_wr_ok(reg_wr_ok),
      .reg_raddr(reg_raddr),
      .reg_rdata(reg_rdata),
      .reg_rd_ok(reg_rd_ok)
   );

   assign reg_wr_ok = (reg_waddr == fct_pkg::OFF_CTRL);

   always_comb begin
      reg_rdata = 32'h0000_0000;
      reg_rd_ok = 1'b1;
      case (reg_raddr)
         fct_pkg::OFF_CTRL: begin
            reg_rdata[fct_pkg::CTRL_EN_BIT] = s_r.en;
            reg_rdata[fct_pkg::CTRL_WID_LSB +: 2] = s_r.wid;
         end
         fct_pkg::OFF_STATUS: begin
            reg_rdata[fct_pkg::ST_STATE_LSB +: 4] = s_r.st;
            reg_rdata[fct_pkg::ST_PHASE_LSB +: 2] = s_r.lph;
            reg_rdata[fct_pkg::ST_REP_BIT] = s_r.rep_on;
         end
         fct_pkg::OFF_VIOL: begin
            reg_rdata[15:0] = s_r.viol;
         end
         default: begin
            reg_rd_ok = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // character timing and indications
   // ----------------------------------------------------------------
   assign tick = (s_r.div == DIV_LAST);
   assign bnd = (s_r.lph == 2'h0);

   always_comb begin
      nlanes = 3'd4;
      ind = 1'b0;
      case (s_r.wid)
         fct_pkg::FCT_W_BYTE: begin
            nlanes = 3'd1;
            ind = tick;
         end
         fct_pkg::FCT_W_HALF: begin
            nlanes = 3'd2;
            ind = tick && !s_r.lph[0];
         end
         default: begin
            nlanes = 3'd4;
            ind = tick && bnd;
         end
      endcase
      // no indications once failed
      ind = ind && (s_r.st != fct_pkg::FCT_ST_FAIL);
   end

   assign tx_clk_ind = ind;
   assign tx_boundary_word = ind && bnd;
   assign req_ready = ind;
   assign take = ind && req_valid;

   // repeating set, or idle, fills a word nobody requests
   assign dflt = '{os: 1'b1, code: {24'h000000, s_r.rep_on ? s_r.rep_code
                                                            : fct_pkg::IDLE_OS_CODE}};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic fclr;
      logic is_os;
      logic [1:0] li;
      fclr = 1'b0;
      is_os = 1'b0;
      li = 2'h0;
      s_nxt = s_r;

      // laser trip: three stages, accepted once stages two and three agree
      s_nxt.sync = {s_r.sync[1:0], laser_trip};
      if (s_r.sync[2] == s_r.sync[1]) begin
         s_nxt.trip = s_r.sync[2];
      end

      if (reg_wr && reg_wr_ok && reg_wstrb[0]) begin
         s_nxt.en = reg_wdata[fct_pkg::CTRL_EN_BIT];
         s_nxt.wid = fct_pkg::fct_width_t'(reg_wdata[fct_pkg::CTRL_WID_LSB +: 2]);
         fclr = reg_wdata[fct_pkg::CTRL_FCLR_BIT];
      end

      s_nxt.div = tick ? '0 : s_r.div + CDW'(1);
      if (tick) begin
         s_nxt.lph = s_r.lph + 2'h1;
      end

      // boundary without a request: next word starts as a set
      if (tick && bnd) begin
         s_nxt.stg = dflt;
      end

      if (take) begin
         is_os = (req.ty[0] == fct_pkg::FCT_TY_NREP_OS) ||
                 (req.ty[0] == fct_pkg::FCT_TY_REP_OS);
         if (is_os && !bnd) begin
            if (s_r.st == fct_pkg::FCT_ST_WORK) begin
               s_nxt.st = fct_pkg::FCT_ST_FAIL;
            end
            s_nxt.viol = s_r.viol + 16'h0001;
         end else if (is_os) begin
            // one type and code for any width
            s_nxt.stg.os = 1'b1;
            s_nxt.stg.code = {24'h000000, req.code[0]};
            s_nxt.rep_on = (req.ty[0] == fct_pkg::FCT_TY_REP_OS);
            s_nxt.rep_code = req.code[0];
         end else if (bnd || !s_r.stg.os) begin
            if (bnd) begin
               s_nxt.stg.os = 1'b0;
               s_nxt.stg.code = '0;
            end
            for (int i = 0; i < 4; i++) begin
               li = s_r.lph + 2'(i);
               if (3'(i) < nlanes) begin
                  s_nxt.stg.code[li] = req.code[i];
               end
            end
            s_nxt.rep_on = 1'b0;
         end
      end

      // transmitter state
      if (s_r.st == fct_pkg::FCT_ST_FAIL) begin
         if (fclr) begin
            s_nxt.st = fct_pkg::FCT_ST_NOT_EN;
         end
      end else if (s_nxt.st != fct_pkg::FCT_ST_FAIL) begin
         if (s_r.trip) begin
            s_nxt.st = fct_pkg::FCT_ST_OPEN;
         end else if (s_r.en) begin
            s_nxt.st = fct_pkg::FCT_ST_WORK;
         end else begin
            s_nxt.st = fct_pkg::FCT_ST_NOT_EN;
         end
      end

      // fresh word alignment, idle words first
      enter_work = (s_nxt.st == fct_pkg::FCT_ST_WORK) && (s_r.st != fct_pkg::FCT_ST_WORK);
      if (enter_work) begin
         s_nxt.div = '0;
         s_nxt.lph = 2'h0;
         s_nxt.stg = '{os: 1'b1, code: {24'h000000, fct_pkg::IDLE_OS_CODE}};
         s_nxt.rep_on = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // line side
   // ----------------------------------------------------------------
   fct_lane_ser u_ser (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(enter_work),
      .tick(tick),
      .load(bnd),
      .word(s_r.stg),
      .out_char(line_char),
      .out_stb(ser_stb)
   );

   assign line_en = (s_r.st == fct_pkg::FCT_ST_WORK);
   assign line_char_valid = ser_stb && line_en;
   assign tx_state = s_r.st;

endmodule // fct_tx_req

// file: rtl/fct_pkg.sv
// types and constants for the transmit clock indication and data request block
package fct_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_VIOL = 4'h8;

   // control: enable, failure clear (self clearing), path width
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FCLR_BIT = 1;
   localparam int CTRL_WID_LSB = 2;
   localparam logic CTRL_EN_RST = 1'b0;

   // status: one-hot state, lane phase, repeat active
   localparam int ST_STATE_LSB = 0;
   localparam int ST_PHASE_LSB = 4;
   localparam int ST_REP_BIT = 6;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   // serial bits per transmission character; one lane per character time
   localparam int LINE_BITS_PER_CHAR = 10;
   // clock cycles per character time, default of the block parameter
   localparam int CHAR_CYC_DEF = 4;

   // idle ordered set code, value arbitrary
   localparam logic [7:0] IDLE_OS_CODE = 8'h01;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FCT_TY_DATA = 2'h0,
      FCT_TY_NREP_OS = 2'h1,
      FCT_TY_REP_OS = 2'h2
   } fct_lane_ty_t;

   typedef enum logic [1:0] {
      FCT_W_BYTE = 2'h0,
      FCT_W_HALF = 2'h1,
      FCT_W_WORD = 2'h2
   } fct_width_t;

   typedef enum logic [3:0] {
      FCT_ST_NOT_EN = 4'b0001,
      FCT_ST_WORK = 4'b0010,
      FCT_ST_OPEN = 4'b0100,
      FCT_ST_FAIL = 4'b1000
   } fct_state_t;

   // data request: lane 0 is the first lane
   typedef struct packed {
      fct_lane_ty_t [3:0] ty;
      logic [3:0][7:0] code;
   } fct_req_t;

   // one transmission word waiting for the line
   typedef struct packed {
      logic os;
      logic [3:0][7:0] code;
   } fct_word_t;

   // one character on the line; k marks the first character of an ordered set
   typedef struct packed {
      logic k;
      logic [7:0] code;
   } fct_char_t;

endpackage

// file: rtl/fct_axil_slv.sv
// axi4-lite slave front end for the transmit block registers
`timescale 1ns/100ps
module fct_axil_slv (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [fct_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [fct_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic reg_wr,
   output logic [fct_pkg::ADDR_W-1:0] reg_waddr,
   output logic [31:0] reg_wdata,
   output logic [3:0] reg_wstrb,
   input wire logic reg_wr_ok,
   output logic [fct_pkg::ADDR_W-1:0] reg_raddr,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rd_ok
);

   typedef struct packed {
      logic aw_h;
      logic w_h;
      logic [fct_pkg::ADDR_W-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fct_slv_s_t;

   fct_slv_s_t s_r;
   fct_slv_s_t s_nxt;

   assign awready = !s_r.aw_h && !s_r.bvalid;
   assign wready = !s_r.w_h && !s_r.bvalid;
   assign arready = !s_r.rvalid;
   assign reg_wr = s_r.aw_h && s_r.w_h && !s_r.bvalid;
   assign reg_waddr = s_r.waddr;
   assign reg_wdata = s_r.wdata;
   assign reg_wstrb = s_r.wstrb;
   assign reg_raddr = araddr;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign rvalid = s_r.rvalid;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;

   always_comb begin
      s_nxt = s_r;
      if (awvalid && awready) begin
         s_nxt.aw_h = 1'b1;
         s_nxt.waddr = awaddr;
      end
      if (wvalid && wready) begin
         s_nxt.w_h = 1'b1;
         s_nxt.wdata = wdata;
         s_nxt.wstrb = wstrb;
      end
      // both halves held: commit and answer
      if (reg_wr) begin
         s_nxt.aw_h = 1'b0;
         s_nxt.w_h = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = reg_wr_ok ? fct_pkg::RESP_OKAY : fct_pkg::RESP_SLVERR;
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = reg_rd_ok ? reg_rdata : 32'h0000_0000;
         s_nxt.rresp = reg_rd_ok ? fct_pkg::RESP_OKAY : fct_pkg::RESP_SLVERR;
      end
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // fct_axil_slv

// file: rtl/fct_lane_ser.sv
// shifts a transmission word onto the line one lane per character time
`timescale 1ns/100ps
module fct_lane_ser (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clr,
   input wire logic tick,
   input wire logic load,
   input wire fct_pkg::fct_word_t word,
   output fct_pkg::fct_char_t out_char,
   output logic out_stb
);

   typedef struct packed {
      logic [2:0][7:0] rest;
      fct_pkg::fct_char_t out;
      logic stb;
   } fct_ser_s_t;

   fct_ser_s_t s_r;
   fct_ser_s_t s_nxt;

   assign out_char = s_r.out;
   assign out_stb = s_r.stb;

   always_comb begin
      s_nxt = s_r;
      s_nxt.stb = tick;
      if (clr) begin
         s_nxt = '0;
      end else if (tick && load) begin
         // lane 0 goes out first, the others follow in order
         s_nxt.out.k = word.os;
         s_nxt.out.code = word.code[0];
         s_nxt.rest = word.code[3:1];
      end else if (tick) begin
         s_nxt.out.k = 1'b0;
         s_nxt.out.code = s_r.rest[0];
         s_nxt.rest = {8'h00, s_r.rest[2:1]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // fct_lane_ser

// file: tb/fct_tx_props.sv
// concurrent checks of the indication, request and line ports
`timescale 1ns/100ps
module fct_tx_props #(
   parameter int unsigned CHAR_CYC = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tx_clk_ind,
   input wire logic tx_boundary_word,
   input wire logic req_valid,
   input wire fct_pkg::fct_req_t req,
   input wire logic req_ready,
   input wire logic line_char_valid,
   input wire logic line_en,
   input wire fct_pkg::fct_state_t tx_state
);
   // ----------
   // gap counters
   // ----------
   int gap_r;
   int bgap_r;
   logic gap_ok_r;
   logic bgap_ok_r;
   logic work;
   logic bnd;
   assign work = tx_state == fct_pkg::FCT_ST_WORK;
   assign bnd = tx_clk_ind && tx_boundary_word;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r <= 0;
         bgap_r <= 0;
         gap_ok_r <= 1'b0;
         bgap_ok_r <= 1'b0;
      end else begin
         gap_r <= tx_clk_ind ? 1 : gap_r + 1;
         bgap_r <= bnd ? 1 : bgap_r + 1;
         gap_ok_r <= work && (gap_ok_r || tx_clk_ind);
         bgap_ok_r <= work && (bgap_ok_r || bnd);
      end
   end
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_enter_work;
      $rose(work);
   endsequence
   sequence s_bad_req;
      work && tx_clk_ind && !tx_boundary_word && req_valid
         && req.ty[0] != fct_pkg::FCT_TY_DATA;
   endsequence
   a_fail_quiet: assert property (tx_state == fct_pkg::FCT_ST_FAIL |-> !tx_clk_ind)
      else $error("indication in failure");
   a_fail_refuse: assert property (tx_state == fct_pkg::FCT_ST_FAIL |-> !req_ready)
      else $error("request ready in failure");
   a_ready_ind: assert property (req_ready == tx_clk_ind)
      else $error("ready not tied to indication");
   a_bound_ind: assert property (tx_boundary_word |-> tx_clk_ind)
      else $error("boundary without indication");
   a_ind_gap: assert property (work && tx_clk_ind && gap_ok_r |->
      gap_r == CHAR_CYC || gap_r == 2 * CHAR_CYC || gap_r == 4 * CHAR_CYC)
      else $error("indication spacing wrong");
   a_bound_gap: assert property (bnd && bgap_ok_r && work |-> bgap_r == 4 * CHAR_CYC)
      else $error("word boundary spacing wrong");
   a_fail_entry: assert property (s_bad_req |=> tx_state == fct_pkg::FCT_ST_FAIL)
      else $error("no failure after set on null");
   a_enter_tick: assert property (s_enter_work |-> ##[0:12] tx_clk_ind)
      else $error("no indication after entering working");
   a_first_bound: assert property (s_enter_work |-> !tx_clk_ind until bnd)
      else $error("first indication not a boundary");
   a_line_work: assert property (!work |-> !line_char_valid && !line_en)
      else $error("line active outside working");
endmodule // fct_tx_props

bind fct_tx_req fct_tx_props #(.CHAR_CYC(CHAR_CYC)) i_fct_tx_props (
   .aclk(aclk),
   .aresetn(aresetn),
   .tx_clk_ind(tx_clk_ind),
   .tx_boundary_word(tx_boundary_word),
   .req_valid(req_valid),
   .req(req),
   .req_ready(req_ready),
   .line_char_valid(line_char_valid),
   .line_en(line_en),
   .tx_state(tx_state)
);

// file: tb/fct_frm_model.sv
// framing level model issuing queued data requests on indications
`timescale 1ns/100ps
module fct_frm_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tx_clk_ind,
   input wire logic tx_boundary_word,
   input wire fct_pkg::fct_width_t width,
   output logic req_valid,
   output fct_pkg::fct_req_t req
);
   fct_pkg::fct_req_t q[$];
   fct_pkg::fct_req_t head_r;
   logic have_r = 1'b0;
   logic [39:0] junk_r = 40'h5a3c96e10f;
   logic bad = 1'b0;
   logic stall = 1'b0;
   int skip_r = 0;
   logic os;
   task automatic push(input fct_pkg::fct_req_t r);
      q.push_back(r);
   endtask
   assign os = head_r.ty[0] != fct_pkg::FCT_TY_DATA;
   // sets wait for a word boundary unless told to misbehave
   assign req_valid = have_r && tx_clk_ind && !stall && skip_r == 0
      && (!os || tx_boundary_word != bad);
   assign req = req_valid ? head_r : fct_pkg::fct_req_t'(junk_r);
   always @(posedge aclk) begin
      junk_r <= ~junk_r;
      if (!aresetn) begin
         skip_r <= 0;
      end else if (req_valid) begin
         // quiet indications after a set, by path width
         skip_r <= !os ? 0 : width == fct_pkg::FCT_W_BYTE ? 3 :
            width == fct_pkg::FCT_W_HALF ? 1 : 0;
         void'(q.pop_front());
      end else if (tx_clk_ind && skip_r != 0) begin
         skip_r <= skip_r - 1;
      end
      have_r <= q.size() != 0;
      if (q.size() != 0) begin
         head_r <= q[0];
      end
   end
endmodule // fct_frm_model

// file: tb/testbench.sv
// self-checking bench for the transmit indication and request block
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end
module testbench;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, laser_trip, bvalid, rvalid;
   logic awready, wready, arready, tx_clk_ind, tx_boundary_word, req_valid, req_ready;
   logic line_char_valid, line_en;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   fct_pkg::fct_req_t req;
   fct_pkg::fct_char_t line_char;
   fct_pkg::fct_char_t lq[$];
   fct_pkg::fct_state_t tx_state;
   fct_pkg::fct_width_t width;
   int mismatches, n_tests, n_ind;
   fct_tx_req #(.CHAR_CYC(2)) i_fct_tx_req (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .laser_trip(laser_trip), .tx_clk_ind(tx_clk_ind),
      .tx_boundary_word(tx_boundary_word), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .line_char(line_char), .line_char_valid(line_char_valid),
      .line_en(line_en), .tx_state(tx_state));
   fct_frm_model i_fct_frm_model (.aclk(aclk), .aresetn(aresetn), .tx_clk_ind(tx_clk_ind),
      .tx_boundary_word(tx_boundary_word), .width(width), .req_valid(req_valid), .req(req));
   // ----------
   // clock, monitors, closing
   // ----------
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (tx_clk_ind) n_ind++;
      if (aresetn && line_char_valid) lq.push_back(line_char);
   end
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ----------
   // bus and stream tasks
   // ----------
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      `CHK(bresp, er)
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
   task automatic wait_state(input fct_pkg::fct_state_t s);
      int n;
      n = 0;
      while (tx_state !== s && n < 50) begin
         @(posedge aclk);
         n++;
      end
      `CHK(tx_state, s)
   endtask
   task automatic set_mode(input fct_pkg::fct_width_t w);
      int k;
      axi_wr(fct_pkg::OFF_CTRL, {28'h0, width, 2'b00}, fct_pkg::RESP_OKAY);
      wait_state(fct_pkg::FCT_ST_NOT_EN);
      width <= w;
      axi_wr(fct_pkg::OFF_CTRL, {28'h0, w, 2'b01}, fct_pkg::RESP_OKAY);
      wait_state(fct_pkg::FCT_ST_WORK);
      k = n_ind;
      repeat (32) @(posedge aclk);
      `CHK(n_ind - k, w == fct_pkg::FCT_W_BYTE ? 16 : w == fct_pkg::FCT_W_HALF ? 8 : 4)
      lq.delete();
   endtask
   task automatic send(input fct_pkg::fct_lane_ty_t t, input logic [31:0] c);
      fct_pkg::fct_req_t r;
      for (int i = 0; i < 4; i++) begin
         r.ty[i] = (i == 0) ? t : fct_pkg::FCT_TY_DATA;
         r.code[i] = c[8*i +: 8];
      end
      i_fct_frm_model.push(r);
   endtask
   // finds w0 on the line, then checks the three characters after it
   task automatic expect_word(input logic [8:0] w0, w1, w2, w3);
      int i, n;
      i = -1;
      n = 0;
      while (i < 0 && n < 300) begin
         @(posedge aclk);
         n++;
         foreach (lq[j]) if (i < 0 && lq[j] === w0 && j + 3 < lq.size()) i = j;
      end
      `CHK(i >= 0, 1'b1)
      if (i >= 0) begin
         `CHK(lq[i+1], w1)
         `CHK(lq[i+2], w2)
         `CHK(lq[i+3], w3)
         lq = lq[i+4:$];
      end
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      int k;
      axi_rd(fct_pkg::OFF_CTRL, d, r);
      `CHK(d[0], fct_pkg::CTRL_EN_RST)
      axi_rd(fct_pkg::OFF_STATUS, d, r);
      `CHK(d[3:0], fct_pkg::FCT_ST_NOT_EN)
      axi_rd(4'hc, d, r);
      `CHK(r, fct_pkg::RESP_SLVERR)
      axi_wr(fct_pkg::OFF_STATUS, 32'hf, fct_pkg::RESP_SLVERR);
      k = n_ind;
      repeat (20) @(posedge aclk);
      `CHK(n_ind > k, 1'b1)
   endtask
   task automatic t_word;
      set_mode(fct_pkg::FCT_W_WORD);
      expect_word({1'b1, fct_pkg::IDLE_OS_CODE}, 9'h0, 9'h0, 9'h0);
      send(fct_pkg::FCT_TY_DATA, 32'hd4c3b2a1);
      send(fct_pkg::FCT_TY_NREP_OS, 32'h5c);
      send(fct_pkg::FCT_TY_DATA, 32'h44332211);
      expect_word(9'h0a1, 9'h0b2, 9'h0c3, 9'h0d4);
      expect_word(9'h15c, 9'h0, 9'h0, 9'h0);
      expect_word(9'h011, 9'h022, 9'h033, 9'h044);
   endtask
   task automatic t_repeat;
      logic [31:0] d;
      logic [1:0] r;
      send(fct_pkg::FCT_TY_REP_OS, 32'h3e);
      expect_word(9'h13e, 9'h0, 9'h0, 9'h0);
      expect_word(9'h13e, 9'h0, 9'h0, 9'h0);
      axi_rd(fct_pkg::OFF_STATUS, d, r);
      `CHK(d[fct_pkg::ST_REP_BIT], 1'b1)
      send(fct_pkg::FCT_TY_DATA, 32'h88776655);
      expect_word(9'h055, 9'h066, 9'h077, 9'h088);
      axi_rd(fct_pkg::OFF_STATUS, d, r);
      `CHK(d[fct_pkg::ST_REP_BIT], 1'b0)
   endtask
   task automatic t_narrow(input fct_pkg::fct_width_t w);
      set_mode(w);
      send(fct_pkg::FCT_TY_NREP_OS, 32'h5c);
      if (w == fct_pkg::FCT_W_HALF) begin
         send(fct_pkg::FCT_TY_DATA, 32'h2211);
         send(fct_pkg::FCT_TY_DATA, 32'h4433);
      end else begin
         for (int i = 1; i < 5; i++) send(fct_pkg::FCT_TY_DATA, 32'(i * 17));
      end
      expect_word(9'h15c, 9'h0, 9'h0, 9'h0);
      expect_word(9'h011, 9'h022, 9'h033, 9'h044);
   endtask
   task automatic t_fail;
      logic [31:0] d;
      logic [1:0] r;
      int k;
      set_mode(fct_pkg::FCT_W_BYTE);
      i_fct_frm_model.bad = 1'b1;
      send(fct_pkg::FCT_TY_NREP_OS, 32'h7a);
      wait_state(fct_pkg::FCT_ST_FAIL);
      i_fct_frm_model.bad = 1'b0;
      k = n_ind;
      repeat (40) @(posedge aclk);
      `CHK(n_ind, k)
      axi_rd(fct_pkg::OFF_VIOL, d, r);
      `CHK(d[15:0], 16'h1)
      axi_wr(fct_pkg::OFF_CTRL, 32'h2, fct_pkg::RESP_OKAY);
      wait_state(fct_pkg::FCT_ST_NOT_EN);
   endtask
   task automatic t_trip;
      int k;
      set_mode(fct_pkg::FCT_W_WORD);
      laser_trip <= 1'b1;
      wait_state(fct_pkg::FCT_ST_OPEN);
      k = n_ind;
      repeat (20) @(posedge aclk);
      `CHK(n_ind > k, 1'b1)
      laser_trip <= 1'b0;
      wait_state(fct_pkg::FCT_ST_WORK);
      lq.delete();
      expect_word({1'b1, fct_pkg::IDLE_OS_CODE}, 9'h0, 9'h0, 9'h0);
   endtask
   initial begin
      {awvalid, wvalid, arvalid, laser_trip, aresetn} = '0;
      {bready, rready} = 2'b11;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      width = fct_pkg::FCT_W_BYTE;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_word();
      t_repeat();
      t_narrow(fct_pkg::FCT_W_BYTE);
      t_narrow(fct_pkg::FCT_W_HALF);
      t_fail();
      t_trip();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      $display("wrong value at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule // testbench
